// ### hw/host_ctl_pkg.sv
package host_ctl_pkg;

	// Local clock generator: input clock divided by four gives two phases 90 degrees apart
	localparam int unsigned LOCAL_CLOCK_DIV     = 4;
	localparam logic [1:0]  PHASE_RESET         = 2'h0;
	localparam logic [1:0]  PHASE_LAST          = 2'h3;

	// Host control word: only the halt bit is modelled
	localparam int unsigned HALT_BIT_POS        = 0;
	localparam logic        HALT_BIT_RESET      = 1'b1;
	localparam logic [15:0] HOST_CONTROL_RESET  = 16'h0001;

	// Host side timing, given in nanoseconds and rounded up to cycles of its clock
	localparam int unsigned CLOCK_PERIOD_NS     = 8;
	localparam int unsigned STROBE_SETUP_NS     = 16;
	localparam int unsigned STROBE_SETUP_CYCLES =
		(STROBE_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam logic [3:0]  SETUP_RESET         = 4'h0;
	localparam logic [3:0]  SETUP_LOAD          = 4'(STROBE_SETUP_CYCLES);

	typedef enum logic [1:0] {HALTED, RUNNING} run_state_t;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_WAIT, H_RELEASE} host_state_t;

endpackage

// ### hw/host_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface host_link_if;
	logic        host_read_strobe_n;
	logic        host_write_strobe_n;
	logic        host_select_n;
	logic [15:0] write_data;
	logic [15:0] read_data;
	logic        host_ready_out;
	logic        local_clock_phase_a;
	logic        local_clock_phase_b;

	modport device
	(
		input  host_read_strobe_n, host_write_strobe_n, host_select_n, write_data,
		output read_data, host_ready_out, local_clock_phase_a, local_clock_phase_b
	);
	modport host
	(
		output host_read_strobe_n, host_write_strobe_n, host_select_n, write_data,
		input  read_data, host_ready_out, local_clock_phase_a, local_clock_phase_b
	);
endinterface
`default_nettype wire

// ### hw/system_control.sv
// Overview of operation
// R01: Host pulls read strobe low to read
// R02: Host pulls write strobe low to write
// R03: Write data valid at write strobe rise
// R04: Read and write strobes never together
// R05: Logic runs on clock from input clock
// R06: Two local clocks, quarter period apart
// R07: Outputs change on local clock edges
// R08: Two active-low local interrupt inputs
// R09: Interrupter holds line until recognised
// R10: Interrupt inputs synchronised before use
// R11: Reset gives known state, outputs inactive
// R12: Select low at reset release: bootstrap
// R13: Select high: halt until halt bit cleared
// R14: Host select low enables host access
// R15: Ready low normally, high when completing
// R16: Two synchroniser stages per interrupt input
`timescale 1ns/10ps
`default_nettype none
module system_control
	import host_ctl_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  reset_n,
	host_link_if.device link,
	input  wire logic  local_irq_a_n,
	input  wire logic  local_irq_b_n,
	input  wire logic  irq_acknowledge_a,
	input  wire logic  irq_acknowledge_b,
	output logic       irq_pending_a,
	output logic       irq_pending_b,
	output logic       running,
	output logic       bootstrap,
	output logic [15:0] host_control_low,
	output logic       write_event
);

	typedef struct packed {
		logic [1:0]  phase;
		logic        clk_a;
		logic        clk_b;
		logic [1:0]  irq_meta;
		logic [1:0]  irq_sync;
		logic [2:0]  sel_sync;
		logic [2:0]  rd_sync;
		logic [2:0]  wr_sync;
		logic [1:0]  strap_fill;
		logic        strap_taken;
		logic        boot;
		run_state_t  run;
		logic [15:0] control;
		logic        ready;
		logic        wr_pulse;
		logic        irq_a;
		logic        irq_b;
	} state_t;

	state_t cur;
	state_t next_cur;
	logic   write_rise;
	logic   access;

	// Synchronisers reset to the idle level of their pins, so release makes no false edge
	localparam state_t CUR_RESET = '{
		phase:       PHASE_RESET,
		clk_a:       1'b0,
		clk_b:       1'b0,
		irq_meta:    2'h0,
		irq_sync:    2'h0,
		sel_sync:    3'h7,
		rd_sync:     3'h7,
		wr_sync:     3'h7,
		strap_fill:  2'h0,
		strap_taken: 1'b0,
		boot:        1'b0,
		run:         HALTED,
		control:     HOST_CONTROL_RESET,
		ready:       1'b0,
		wr_pulse:    1'b0,
		irq_a:       1'b0,
		irq_b:       1'b0
	}; // R11

	always_comb
	begin
		next_cur = cur;
		// Divider gives two clocks of equal duty, b trailing a by one quarter period
		next_cur.phase = cur.phase + 2'h1; // R05
		// Local clocks are plain registers, so they carry the same delay as every output taken straight from a register
		case (cur.phase)
			PHASE_RESET:
			begin
				next_cur.clk_a = 1'b1; // R06
				next_cur.clk_b = 1'b0;
			end
			2'h1:
			begin
				next_cur.clk_a = 1'b1;
				next_cur.clk_b = 1'b1; // R06
			end
			2'h2:
			begin
				next_cur.clk_a = 1'b0;
				next_cur.clk_b = 1'b1;
			end
			default:
			begin
				next_cur.clk_a = 1'b0;
				next_cur.clk_b = 1'b0;
			end
		endcase
		// First stage is read only by the second; only the second is used
		next_cur.irq_meta = {~local_irq_b_n, ~local_irq_a_n}; // R10
		next_cur.irq_sync = cur.irq_meta; // R16
		next_cur.sel_sync = {cur.sel_sync[1:0], link.host_select_n};
		next_cur.rd_sync  = {cur.rd_sync[1:0], link.host_read_strobe_n};
		next_cur.wr_sync  = {cur.wr_sync[1:0], link.host_write_strobe_n};
		// Sticky requests; a new request wins over an acknowledge in the same cycle
		if (cur.irq_sync[0])
		begin
			next_cur.irq_a = 1'b1; // R08
		end
		else if (irq_acknowledge_a)
		begin
			next_cur.irq_a = 1'b0;
		end
		if (cur.irq_sync[1])
		begin
			next_cur.irq_b = 1'b1; // R08
		end
		else if (irq_acknowledge_b)
		begin
			next_cur.irq_b = 1'b0;
		end
		// Strap waits until the select synchroniser holds a sample taken after release;
		// its reset value says nothing about the pin
		next_cur.strap_fill = {cur.strap_fill[0], 1'b1};
		if (cur.strap_fill[1] && !cur.strap_taken)
		begin
			next_cur.strap_taken = 1'b1;
			next_cur.boot = ~cur.sel_sync[1]; // R12
			next_cur.run  = cur.sel_sync[1] ? HALTED : RUNNING; // R13
			next_cur.control[HALT_BIT_POS] = cur.sel_sync[1];
		end
		// Write lands only while selected; a bare strobe edge is ignored
		next_cur.wr_pulse = 1'b0;
		if (write_rise && access)
		begin
			next_cur.control = link.write_data; // R03
			next_cur.wr_pulse = 1'b1;
		end
		if (cur.strap_taken)
		begin
			case (cur.run)
				HALTED:
				begin
					if (!next_cur.control[HALT_BIT_POS])
					begin
						next_cur.run = RUNNING; // R13
					end
				end
				default:
				begin
					next_cur.run = RUNNING;
				end
			endcase
		end
		// Ready rises while a strobe is held, drops once it is released
		if (access && (!cur.rd_sync[1] || !cur.wr_sync[1]))
		begin
			next_cur.ready = 1'b1; // R15
		end
		else
		begin
			next_cur.ready = 1'b0;
		end
	end

	// Write data taken at the rising edge of the write strobe
	assign write_rise = cur.wr_sync[1] && !cur.wr_sync[2]; // R03
	assign access     = !cur.sel_sync[1]; // R14

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cur <= CUR_RESET; // R11
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// Outputs come from flip-flops on the same clock as the local clocks; running is an AND of two of them
	assign link.local_clock_phase_a = cur.clk_a; // R07
	assign link.local_clock_phase_b = cur.clk_b;
	assign link.host_ready_out      = cur.ready; // R07
	assign link.read_data           = cur.control;
	assign irq_pending_a            = cur.irq_a;
	assign irq_pending_b            = cur.irq_b;
	assign running                  = (cur.run == RUNNING) && cur.strap_taken;
	assign bootstrap                = cur.boot;
	assign host_control_low         = cur.control;
	assign write_event              = cur.wr_pulse;

endmodule
`default_nettype wire

// ### hw/host_master.sv
`timescale 1ns/10ps
`default_nettype none
module host_master
	import host_ctl_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  reset_n,
	host_link_if.host  link,
	input  wire logic  select_at_reset_n,
	input  wire logic  request_valid,
	input  wire logic  request_write,
	input  wire logic [15:0] request_data,
	output logic       request_ready,
	output logic [15:0] response_data,
	output logic       response_valid
);

	typedef struct packed {
		host_state_t state;
		logic        write;
		logic [15:0] data;
		logic [15:0] rdata;
		logic        rvalid;
		logic [3:0]  count;
		logic        sel_n;
		logic        rd_n;
		logic        wr_n;
		logic [1:0]  rdy_meta;
	} state_t;

	state_t cur;
	state_t next_cur;

	always_comb
	begin
		next_cur = cur;
		next_cur.rvalid = 1'b0;
		next_cur.rdy_meta = {cur.rdy_meta[0], link.host_ready_out};
		case (cur.state)
			H_IDLE:
			begin
				next_cur.sel_n = select_at_reset_n;
				if (request_valid)
				begin
					next_cur.write = request_write;
					next_cur.data  = request_data;
					next_cur.sel_n = 1'b0; // R14
					next_cur.count = SETUP_LOAD;
					next_cur.state = H_SETUP;
				end
			end
			H_SETUP:
				if (cur.count == SETUP_RESET)
				begin
					// Only one strobe is ever low at a time
					next_cur.rd_n  = cur.write; // R01 R04
					next_cur.wr_n  = ~cur.write; // R02 R04
					next_cur.state = H_STROBE;
				end
				else
					next_cur.count = cur.count - 4'h1;
			H_STROBE:
				if (cur.rdy_meta[1])
					next_cur.state = H_WAIT;
			H_WAIT:
			begin
				// Data already on the bus; raising write strobe marks it valid
				next_cur.rd_n  = 1'b1;
				next_cur.wr_n  = 1'b1; // R03
				next_cur.rdata = link.read_data;
				next_cur.rvalid = ~cur.write;
				next_cur.state = H_RELEASE;
			end
			default:
				if (!cur.rdy_meta[1])
				begin
					next_cur.sel_n = select_at_reset_n;
					next_cur.state = H_IDLE;
				end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cur <= '{state: H_IDLE, write: 1'b0, data: 16'h0000, rdata: 16'h0000,
				rvalid: 1'b0, count: SETUP_RESET, sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
				rdy_meta: 2'h0};
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// Halt bit cleared by writing 0 through the ordinary write path
	// Select shows the strap level whenever idle, reset included, so it stands at release
	assign link.host_select_n       = request_ready ? select_at_reset_n : cur.sel_n; // R12 R13
	assign link.host_read_strobe_n  = cur.rd_n;
	assign link.host_write_strobe_n = cur.wr_n;
	assign link.write_data          = cur.data;
	assign request_ready            = (cur.state == H_IDLE);
	assign response_data            = cur.rdata;
	assign response_valid           = cur.rvalid;

endmodule
`default_nettype wire

// ### verif/host_link_props.sv
`timescale 1ns/10ps
`default_nettype none
module host_link_props
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        host_read_strobe_n,
	input wire logic        host_write_strobe_n,
	input wire logic        host_select_n,
	input wire logic [15:0] write_data,
	input wire logic [15:0] read_data,
	input wire logic        host_ready_out,
	input wire logic        local_clock_phase_a,
	input wire logic        local_clock_phase_b
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_excl; !(!host_read_strobe_n && !host_write_strobe_n); endproperty
	a_excl: assert property (p_excl) else $error("strobes overlap");
	property p_lag; local_clock_phase_b == $past(local_clock_phase_a); endproperty
	a_lag: assert property (p_lag) else $error("phase b not a quarter behind");
	property p_period; $rose(local_clock_phase_a) |=>
		local_clock_phase_a ##1 !local_clock_phase_a [*2] ##1 local_clock_phase_a; endproperty
	a_period: assert property (p_period) else $error("local clock period wrong");
	property p_rdy_sel; $rose(host_ready_out) |->
		!host_select_n && !(host_read_strobe_n && host_write_strobe_n); endproperty
	a_rdy_sel: assert property (p_rdy_sel) else $error("ready without access");
	property p_rdy_time; $fell(host_read_strobe_n) |-> !host_ready_out ##[2:6] host_ready_out;
	endproperty
	a_rdy_time: assert property (p_rdy_time) else $error("ready late");
	property p_rdy_drop; $rose(host_write_strobe_n) |-> ##[1:5] !host_ready_out; endproperty
	a_rdy_drop: assert property (p_rdy_drop) else $error("ready stuck");
	property p_strb_sel; !(host_read_strobe_n && host_write_strobe_n) |-> !host_select_n;
	endproperty
	a_strb_sel: assert property (p_strb_sel) else $error("strobe unselected");
	property p_wdata; !host_write_strobe_n |=> host_write_strobe_n || $stable(write_data);
	endproperty
	a_wdata: assert property (p_wdata) else $error("write data moved");
	property p_rdata; $changed(read_data) |-> !host_select_n; endproperty
	a_rdata: assert property (p_rdata) else $error("control changed idle");
	c_rd: cover property ($fell(host_read_strobe_n));
	c_wr: cover property ($rose(host_write_strobe_n));
	c_rdy: cover property ($rose(host_ready_out));
endmodule
`default_nettype wire

// ### verif/host_strobe_reset_boot_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module host_strobe_reset_boot_control_bench
	import host_ctl_pkg::*;
;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        strap_n = 1'b1, rv = 1'b0, rw = 1'b0;
	logic [15:0] rd = 16'h0000, q, rsp_d, ctl;
	logic [1:0]  irq_n = 2'h3, ack = 2'h0;
	wire  [1:0]  pend;
	logic        rdy, rsp, run, boot, wev;
	int          miscompares = 0, check_count = 0;
	int          write_count = 0;
	host_link_if lk();
	system_control system_control_i(.clock(clock), .reset_n(reset_n), .link(lk.device),
		.local_irq_a_n(irq_n[0]), .local_irq_b_n(irq_n[1]), .irq_acknowledge_a(ack[0]),
		.irq_acknowledge_b(ack[1]), .irq_pending_a(pend[0]), .irq_pending_b(pend[1]),
		.running(run), .bootstrap(boot), .host_control_low(ctl), .write_event(wev));
	host_master host_master_i(.clock(clock), .reset_n(reset_n), .link(lk.host),
		.select_at_reset_n(strap_n), .request_valid(rv), .request_write(rw),
		.request_data(rd), .request_ready(rdy), .response_data(rsp_d), .response_valid(rsp));
	host_link_props props_i(.clock(clock), .reset_n(reset_n),
		.host_read_strobe_n(lk.host_read_strobe_n), .host_write_strobe_n(lk.host_write_strobe_n),
		.host_select_n(lk.host_select_n), .write_data(lk.write_data), .read_data(lk.read_data),
		.host_ready_out(lk.host_ready_out), .local_clock_phase_a(lk.local_clock_phase_a),
		.local_clock_phase_b(lk.local_clock_phase_b));
	always #4 clock = ~clock;
	// Write pulses counted over the whole run; exactly one write is ever made
	always @(posedge clock)
		if (wev === 1'b1)
			write_count <= write_count + 1;
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude;
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic boot_up(input logic s);
		@(posedge clock);
		strap_n <= s;
		reset_n <= 1'b0;
		repeat (8) @(posedge clock);
		chk("idle strobes", 16'h0003, 16'({lk.host_read_strobe_n, lk.host_write_strobe_n}));
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic xfer(input logic w, input logic [15:0] d, output logic [15:0] r);
		@(posedge clock);
		rv <= 1'b1;
		rw <= w;
		rd <= d;
		// Request stands until an edge at which the host end is idle and takes it
		#1;
		while (rdy !== 1'b1)
		begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		rv <= 1'b0;
		repeat (40)
		begin
			@(posedge clock);
			#1;
			if ((w ? rdy : rsp) === 1'b1)
				break;
		end
		r = rsp_d;
	endtask
	initial
	begin
		#20000;
		miscompares++;
		conclude();
	end
	initial
	begin
		boot_up(1'b1);
		chk("running", 16'h0000, 16'(run));
		chk("bootstrap", 16'h0000, 16'(boot));
		xfer(1'b0, 16'h0000, q);
		chk("reset control", HOST_CONTROL_RESET, q);
		xfer(1'b1, 16'h1234, q);
		chk("control", 16'h1234, ctl);
		chk("write events", 16'h0001, 16'(write_count));
		chk("running", 16'h0001, 16'(run));
		xfer(1'b0, 16'h0000, q);
		chk("read back", 16'h1234, q);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock);
			irq_n[i] <= 1'b0;
			repeat (2) @(posedge clock);
			#1;
			chk("early pending", 16'h0000, 16'(pend));
			@(posedge clock);
			#1;
			chk("pending", (i == 0) ? 16'h0001 : 16'h0002, 16'(pend));
			@(posedge clock);
			irq_n[i] <= 1'b1;
			// Ack only once the synchroniser has seen the release, else set wins
			repeat (4) @(posedge clock);
			ack[i] <= 1'b1;
			@(posedge clock);
			ack[i] <= 1'b0;
			repeat (2) @(posedge clock);
			#1;
			chk("cleared", 16'h0000, 16'(pend));
		end
		boot_up(1'b0);
		chk("bootstrap", 16'h0001, 16'(boot));
		chk("running", 16'h0001, 16'(run));
		chk("write events", 16'h0001, 16'(write_count));
		conclude();
	end
endmodule
`default_nettype wire
